// [core/usb_regs_pkg.sv]
package usb_regs_pkg;

  // register indices, byte address is four times the index
  localparam logic [5:0] IDX_CTRL        = 6'h00;
  localparam logic [5:0] IDX_STATUS      = 6'h02;
  localparam logic [5:0] IDX_DEV_ADDR    = 6'h03;
  localparam logic [5:0] IDX_FIFO_WP     = 6'h04;
  localparam logic [5:0] IDX_FIFO_RP     = 6'h05;
  localparam logic [5:0] IDX_EPT_LOW     = 6'h06;
  localparam logic [5:0] IDX_EPT_HIGH    = 6'h07;
  localparam logic [5:0] IDX_IRQ_CTRL_A  = 6'h08;
  localparam logic [5:0] IDX_IRQ_CTRL_B  = 6'h09;
  localparam logic [5:0] IDX_FLAGS_A_CLR = 6'h0A;
  localparam logic [5:0] IDX_FLAGS_A_SET = 6'h0B;
  localparam logic [5:0] IDX_FLAGS_B_CLR = 6'h0C;
  localparam logic [5:0] IDX_FLAGS_B_SET = 6'h0D;

  // field positions
  localparam int CTRL_FIFO_EN_BIT   = 5;
  localparam int STATUS_SUSPEND_BIT = 1;
  localparam int STATUS_RESET_BIT   = 0;
  localparam int IRQA_FRAME_BIT     = 7;
  localparam int IRQA_EVENT_BIT     = 6;
  localparam int IRQA_ERROR_BIT     = 5;
  localparam int IRQA_STALL_BIT     = 4;
  localparam int IRQB_TRANSFER_BIT  = 1;
  localparam int IRQB_SETUP_BIT     = 0;
  localparam int FLAG_FRAME_BIT     = 7;
  localparam int FLAG_SUSPEND_BIT   = 6;
  localparam int FLAG_RESUME_BIT    = 5;
  localparam int FLAG_RESET_BIT     = 4;
  localparam int FLAG_CRC_BIT       = 3;
  localparam int FLAG_UNDERRUN_BIT  = 2;
  localparam int FLAG_OVERRUN_BIT   = 1;
  localparam int FLAG_STALL_BIT     = 0;

  // writable bit masks, reserved bits read zero
  localparam logic [7:0]  CTRL_MASK     = 8'h20;
  localparam logic [7:0]  DEV_ADDR_MASK = 8'h7F;
  localparam logic [7:0]  IRQA_MASK     = 8'hF3;
  localparam logic [7:0]  IRQB_MASK     = 8'h03;
  localparam logic [7:0]  FLAGS_B_MASK  = 8'h03;
  localparam logic [15:0] EPT_MASK      = 16'h0FFE;

  // reset values
  localparam logic [7:0]  REG_RESET = 8'h00;
  localparam logic [15:0] EPT_RESET = 16'h0000;
  localparam logic [4:0]  PTR_RESET = 5'h00;

  // timing
  localparam real CLK_MHZ            = 125.0;
  localparam real LINE_RESET_MIN_US  = 2.5;
  localparam int  LINE_RESET_CYCLES  = int'($ceil(LINE_RESET_MIN_US * CLK_MHZ));
  localparam int  IDLE_SUSPEND_MS    = 3;
  localparam int  IDLE_SUSPEND_CYCLES = IDLE_SUSPEND_MS * int'(CLK_MHZ) * 1000;
  localparam int  RESET_CNT_W        = 9;
  localparam int  IDLE_CNT_W         = 20;

endpackage

// [core/usb_device_addr_irq_regs.sv]
// Overview of operation
// - bus reset status sets after SE0 held at least 2.5 us
// - only tokens matching the 7-bit device address are answered; bit 7 reads zero
// - 5-bit done FIFO write pointer; writing it flushes both pointers
// - 5-bit done FIFO read pointer; writing it flushes both pointers
// - 16-bit endpoint table pointer in two bytes; bit 0 always zero
// - only SRAM-addressing pointer bits exist; upper bits read zero
// - frame start interrupt needs its enable and its flag
// - one line event enable gates suspend, resume and reset flags
// - one line error enable gates crc, underrun and overrun flags
// - stall interrupt needs its enable and its flag
// - 2-bit level selects priority; zero suppresses all interrupts
// - control B bit 1 enables transfer done interrupt
// - control B bit 0 enables setup done interrupt
// - flags A read same at both locations; zero writes change nothing
// - frame start flag sets on each received frame start packet
// - suspend flag sets after 3 ms of bus idle
// - with FIFO enabled, completed endpoint table address is pushed
// - underrun flag sets when IN endpoint has no data
// - overrun flag sets when OUT endpoint cannot accept data
module usb_device_addr_irq_regs #(
  parameter int SUSPEND_CYCLES = usb_regs_pkg::IDLE_SUSPEND_CYCLES
) (
  // clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  // wishbone slave
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [7:0]  ADR_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [31:0] DAT_I,
  output logic      [31:0] DAT_O,
  output logic             ACK_O,
  // line state
  input  wire logic        LINE_SE0,
  input  wire logic        LINE_IDLE,
  // token address check
  input  wire logic        TOKEN_VALID,
  input  wire logic [6:0]  TOKEN_ADDR,
  output logic             ADDR_MATCH,
  // transaction events
  input  wire logic        FRAME_START_SEEN,
  input  wire logic        ISO_CHECK_ERROR,
  input  wire logic        IN_UNDERRUN,
  input  wire logic        OUT_OVERRUN,
  input  wire logic        STALL_SENT,
  input  wire logic        TRANSFER_DONE,
  input  wire logic        SETUP_DONE,
  input  wire logic [3:0]  DONE_EP_NUM,
  input  wire logic        DONE_EP_IN,
  // done fifo
  input  wire logic        DONE_FIFO_POP,
  output logic             DONE_FIFO_PUSH,
  output logic      [4:0]  DONE_FIFO_SLOT,
  output logic      [15:0] DONE_FIFO_ENTRY,
  // table pointer and interrupt
  output logic      [15:0] ENDPOINT_TABLE_POINTER,
  output logic             IRQ_REQ,
  output logic      [1:0]  IRQ_LEVEL
);

  function automatic logic [7:0] flag_update(
    input logic [7:0] cur,
    input logic [7:0] clr,
    input logic [7:0] set,
    input logic [7:0] hw
  );
    flag_update = (cur & ~clr) | set | hw;
  endfunction

  // register state
  logic [7:0]  control;
  logic [7:0]  device_address;
  logic [4:0]  done_fifo_write_pointer;
  logic [4:0]  done_fifo_read_pointer;
  logic [15:0] endpoint_table_pointer;
  logic [7:0]  irq_control_a;
  logic [7:0]  irq_control_b;
  logic [7:0]  flags_a;
  logic [7:0]  flags_b;

  // line monitor state
  logic [usb_regs_pkg::RESET_CNT_W-1:0] se0_count;
  logic [usb_regs_pkg::IDLE_CNT_W-1:0]  idle_count;
  logic                                 line_reset_seen;
  logic                                 suspended;

  // bus decode
  wire       access     = CYC_I & STB_I;
  wire       wr_fire    = access & WE_I & ACK_O & SEL_I[0];
  wire [5:0] idx        = ADR_I[7:2];
  wire [7:0] wdata      = DAT_I[7:0];
  wire       wr_ctrl    = wr_fire & (idx == usb_regs_pkg::IDX_CTRL);
  wire       wr_addr    = wr_fire & (idx == usb_regs_pkg::IDX_DEV_ADDR);
  wire       wr_wp      = wr_fire & (idx == usb_regs_pkg::IDX_FIFO_WP);
  wire       wr_rp      = wr_fire & (idx == usb_regs_pkg::IDX_FIFO_RP);
  wire       wr_ept_lo  = wr_fire & (idx == usb_regs_pkg::IDX_EPT_LOW);
  wire       wr_ept_hi  = wr_fire & (idx == usb_regs_pkg::IDX_EPT_HIGH);
  wire       wr_irqa    = wr_fire & (idx == usb_regs_pkg::IDX_IRQ_CTRL_A);
  wire       wr_irqb    = wr_fire & (idx == usb_regs_pkg::IDX_IRQ_CTRL_B);
  wire       wr_fa_clr  = wr_fire & (idx == usb_regs_pkg::IDX_FLAGS_A_CLR);
  wire       wr_fa_set  = wr_fire & (idx == usb_regs_pkg::IDX_FLAGS_A_SET);
  wire       wr_fb_clr  = wr_fire & (idx == usb_regs_pkg::IDX_FLAGS_B_CLR);
  wire       wr_fb_set  = wr_fire & (idx == usb_regs_pkg::IDX_FLAGS_B_SET);

  // line monitor decode
  wire se0_hit  = LINE_SE0 & (se0_count == usb_regs_pkg::RESET_CNT_W'(usb_regs_pkg::LINE_RESET_CYCLES - 1));
  wire idle_hit = LINE_IDLE & ~suspended &
                  (idle_count == usb_regs_pkg::IDLE_CNT_W'(SUSPEND_CYCLES - 1));
  wire resume_hit = suspended & ~LINE_IDLE;

  // flag event vectors
  wire [7:0] events_a = {
    FRAME_START_SEEN,
    idle_hit,
    resume_hit,
    se0_hit,
    ISO_CHECK_ERROR,
    IN_UNDERRUN,
    OUT_OVERRUN,
    STALL_SENT
  };
  wire [7:0] events_b = {6'h00, TRANSFER_DONE, SETUP_DONE};

  // software masks, zero bits leave flags alone
  wire [7:0] clr_a = wr_fa_clr ? wdata : 8'h00;
  wire [7:0] set_a = wr_fa_set ? wdata : 8'h00;
  wire [7:0] clr_b = wr_fb_clr ? (wdata & usb_regs_pkg::FLAGS_B_MASK) : 8'h00;
  wire [7:0] set_b = wr_fb_set ? (wdata & usb_regs_pkg::FLAGS_B_MASK) : 8'h00;

  // set wins over clear
  wire [7:0] next_flags_a = flag_update(flags_a, clr_a, set_a, events_a);
  wire [7:0] next_flags_b = flag_update(flags_b, clr_b, set_b, events_b);

  // done fifo
  wire        fifo_enable = control[usb_regs_pkg::CTRL_FIFO_EN_BIT];
  wire        fifo_flush  = wr_wp | wr_rp;
  wire        fifo_push   = fifo_enable & (TRANSFER_DONE | SETUP_DONE) & ~fifo_flush;
  wire        fifo_pop    = DONE_FIFO_POP & ~fifo_flush;
  wire [15:0] fifo_entry  = (endpoint_table_pointer & usb_regs_pkg::EPT_MASK) +
                            {8'h00, DONE_EP_NUM, DONE_EP_IN, 3'h0};

  // interrupt combine
  wire [1:0] level        = irq_control_a[1:0];
  wire       grp_frame    = irq_control_a[usb_regs_pkg::IRQA_FRAME_BIT] &
                            flags_a[usb_regs_pkg::FLAG_FRAME_BIT];
  wire       grp_event    = irq_control_a[usb_regs_pkg::IRQA_EVENT_BIT] &
                            (flags_a[usb_regs_pkg::FLAG_SUSPEND_BIT] |
                             flags_a[usb_regs_pkg::FLAG_RESUME_BIT] |
                             flags_a[usb_regs_pkg::FLAG_RESET_BIT]);
  wire       grp_error    = irq_control_a[usb_regs_pkg::IRQA_ERROR_BIT] &
                            (flags_a[usb_regs_pkg::FLAG_CRC_BIT] |
                             flags_a[usb_regs_pkg::FLAG_UNDERRUN_BIT] |
                             flags_a[usb_regs_pkg::FLAG_OVERRUN_BIT]);
  wire       grp_stall    = irq_control_a[usb_regs_pkg::IRQA_STALL_BIT] &
                            flags_a[usb_regs_pkg::FLAG_STALL_BIT];
  wire       grp_transfer = irq_control_b[usb_regs_pkg::IRQB_TRANSFER_BIT] &
                            flags_b[usb_regs_pkg::IRQB_TRANSFER_BIT];
  wire       grp_setup    = irq_control_b[usb_regs_pkg::IRQB_SETUP_BIT] &
                            flags_b[usb_regs_pkg::IRQB_SETUP_BIT];
  wire       any_group    = grp_frame | grp_event | grp_error | grp_stall | grp_transfer | grp_setup;
  wire       next_irq     = any_group & (level != 2'h0);

  // status view
  wire [7:0] status_view = {6'h00, suspended, line_reset_seen};

  // read selection
  logic [7:0] read_byte;
  always_comb
  begin
    if (idx == usb_regs_pkg::IDX_CTRL)
      read_byte = control;
    else if (idx == usb_regs_pkg::IDX_STATUS)
      read_byte = status_view;
    else if (idx == usb_regs_pkg::IDX_DEV_ADDR)
      read_byte = device_address & usb_regs_pkg::DEV_ADDR_MASK;
    else if (idx == usb_regs_pkg::IDX_FIFO_WP)
      read_byte = {3'h0, done_fifo_write_pointer};
    else if (idx == usb_regs_pkg::IDX_FIFO_RP)
      read_byte = {3'h0, done_fifo_read_pointer};
    else if (idx == usb_regs_pkg::IDX_EPT_LOW)
      read_byte = endpoint_table_pointer[7:0];
    else if (idx == usb_regs_pkg::IDX_EPT_HIGH)
      read_byte = endpoint_table_pointer[15:8];
    else if (idx == usb_regs_pkg::IDX_IRQ_CTRL_A)
      read_byte = irq_control_a;
    else if (idx == usb_regs_pkg::IDX_IRQ_CTRL_B)
      read_byte = irq_control_b;
    else if (idx == usb_regs_pkg::IDX_FLAGS_A_CLR || idx == usb_regs_pkg::IDX_FLAGS_A_SET)
      read_byte = flags_a;
    else if (idx == usb_regs_pkg::IDX_FLAGS_B_CLR || idx == usb_regs_pkg::IDX_FLAGS_B_SET)
      read_byte = flags_b;
    else
      read_byte = 8'h00;
  end

  // bus answer
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      ACK_O <= 1'b0;
      DAT_O <= 32'h0000_0000;
    end
    else
    begin
      ACK_O <= access & ~ACK_O;
      if (access & ~ACK_O & ~WE_I)
        DAT_O <= {24'h00_0000, read_byte};
    end
  end

  // control registers
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      control                <= usb_regs_pkg::REG_RESET;
      device_address         <= usb_regs_pkg::REG_RESET;
      endpoint_table_pointer <= usb_regs_pkg::EPT_RESET;
      irq_control_a          <= usb_regs_pkg::REG_RESET;
      irq_control_b          <= usb_regs_pkg::REG_RESET;
    end
    else
    begin
      if (wr_ctrl)
        control <= wdata & usb_regs_pkg::CTRL_MASK;
      if (wr_addr)
        device_address <= wdata & usb_regs_pkg::DEV_ADDR_MASK;
      if (wr_ept_lo)
        endpoint_table_pointer[7:0] <= wdata & usb_regs_pkg::EPT_MASK[7:0];
      if (wr_ept_hi)
        endpoint_table_pointer[15:8] <= wdata & usb_regs_pkg::EPT_MASK[15:8];
      if (wr_irqa)
        irq_control_a <= wdata & usb_regs_pkg::IRQA_MASK;
      if (wr_irqb)
        irq_control_b <= wdata & usb_regs_pkg::IRQB_MASK;
    end
  end

  // interrupt flags
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      flags_a <= usb_regs_pkg::REG_RESET;
      flags_b <= usb_regs_pkg::REG_RESET;
    end
    else
    begin
      flags_a <= next_flags_a;
      flags_b <= next_flags_b;
    end
  end

  // bus reset detect
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      se0_count       <= '0;
      line_reset_seen <= 1'b0;
    end
    else if (!LINE_SE0)
    begin
      se0_count       <= '0;
      line_reset_seen <= 1'b0;
    end
    else
    begin
      if (!se0_hit && !line_reset_seen)
        se0_count <= se0_count + 1'b1;
      if (se0_hit)
        line_reset_seen <= 1'b1;
    end
  end

  // idle and suspend detect
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      idle_count <= '0;
      suspended  <= 1'b0;
    end
    else if (!LINE_IDLE)
    begin
      idle_count <= '0;
      suspended  <= 1'b0;
    end
    else if (idle_hit)
      suspended <= 1'b1;
    else if (!suspended)
      idle_count <= idle_count + 1'b1;
  end

  // address match
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      ADDR_MATCH <= 1'b0;
    else
      ADDR_MATCH <= TOKEN_VALID & (TOKEN_ADDR == device_address[6:0]);
  end

  // done fifo pointers
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      done_fifo_write_pointer <= usb_regs_pkg::PTR_RESET;
      done_fifo_read_pointer  <= usb_regs_pkg::PTR_RESET;
      DONE_FIFO_PUSH          <= 1'b0;
      DONE_FIFO_SLOT          <= usb_regs_pkg::PTR_RESET;
      DONE_FIFO_ENTRY         <= usb_regs_pkg::EPT_RESET;
    end
    else
    begin
      DONE_FIFO_PUSH <= fifo_push;
      if (fifo_flush)
      begin
        done_fifo_write_pointer <= usb_regs_pkg::PTR_RESET;
        done_fifo_read_pointer  <= usb_regs_pkg::PTR_RESET;
      end
      else
      begin
        if (fifo_push)
          done_fifo_write_pointer <= done_fifo_write_pointer + 1'b1;
        if (fifo_pop)
          done_fifo_read_pointer <= done_fifo_read_pointer + 1'b1;
      end
      if (fifo_push)
      begin
        DONE_FIFO_SLOT  <= done_fifo_write_pointer;
        DONE_FIFO_ENTRY <= fifo_entry;
      end
    end
  end

  // interrupt and pointer outputs
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      IRQ_REQ                <= 1'b0;
      IRQ_LEVEL              <= 2'h0;
      ENDPOINT_TABLE_POINTER <= usb_regs_pkg::EPT_RESET;
    end
    else
    begin
      IRQ_REQ                <= next_irq;
      IRQ_LEVEL              <= next_irq ? level : 2'h0;
      ENDPOINT_TABLE_POINTER <= endpoint_table_pointer & usb_regs_pkg::EPT_MASK;
    end
  end

endmodule

// [bench/usb_host_model.sv]
module usb_host_model (
  // clock
  input  wire logic       clk,
  // line and token side
  output logic            se0,
  output logic            idle,
  output logic            tok_v,
  output logic      [6:0] tok_a,
  output logic      [4:0] evt
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    se0 = 1'b0;
    idle = 1'b0;
    tok_v = 1'b0;
    tok_a = 7'h2A;
    evt = 5'h00;
  end
  // hold single-ended zero for n sampled edges
  task automatic line_se0(input int n);
    @(posedge clk) se0 <= 1'b1;
    repeat (n) @(posedge clk);
    se0 <= 1'b0;
  endtask
  // hold idle for n sampled edges, then leave idle
  task automatic line_idle(input int n);
    @(posedge clk) idle <= 1'b1;
    repeat (n) @(posedge clk);
    idle <= 1'b0;
  endtask
  // token address lines carry junk once released
  task automatic token(input logic [6:0] a);
    @(posedge clk) tok_v <= 1'b1;
    tok_a <= a;
    @(posedge clk) tok_v <= 1'b0;
    tok_a <= ~a;
  endtask
  task automatic event_pulse(input logic [4:0] e);
    @(posedge clk) evt <= e;
    @(posedge clk) evt <= 5'h00;
  endtask
endmodule

// [bench/usb_regs_checker.sv]
module usb_regs_checker (
  // clock, reset, bus
  input wire logic        REF_CLK,
  input wire logic        RST,
  input wire logic        CYC_I,
  input wire logic        STB_I,
  input wire logic        WE_I,
  input wire logic [7:0]  ADR_I,
  input wire logic [3:0]  SEL_I,
  input wire logic [31:0] DAT_O,
  input wire logic        ACK_O,
  // events and outputs
  input wire logic        TOKEN_VALID,
  input wire logic        ADDR_MATCH,
  input wire logic        TRANSFER_DONE,
  input wire logic        SETUP_DONE,
  input wire logic        DONE_EP_IN,
  input wire logic        DONE_FIFO_PUSH,
  input wire logic [4:0]  DONE_FIFO_SLOT,
  input wire logic [15:0] DONE_FIFO_ENTRY,
  input wire logic [15:0] ENDPOINT_TABLE_POINTER,
  input wire logic        IRQ_REQ,
  input wire logic [1:0]  IRQ_LEVEL
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);
  // expected write pointer: pushes count up, a pointer write flushes
  logic [4:0] slot_model;
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      slot_model <= 5'h00;
    else if (CYC_I && STB_I && WE_I && ACK_O && SEL_I[0] && (ADR_I[7:2] == 6'h04 || ADR_I[7:2] == 6'h05))
      slot_model <= 5'h00;
    else if (DONE_FIFO_PUSH)
      slot_model <= slot_model + 5'h01;
  end
  sequence req_s;
    CYC_I && STB_I && !ACK_O;
  endsequence
  sequence done_s;
    TRANSFER_DONE || SETUP_DONE;
  endsequence
  ack_timing_a: assert property (req_s |=> ACK_O) else $error("ack late");
  ack_pulse_a: assert property (ACK_O |=> !ACK_O) else $error("ack too long");
  ack_cause_a: assert property (ACK_O |-> $past(CYC_I && STB_I)) else $error("ack without request");
  read_upper_a: assert property (ACK_O |-> DAT_O[31:8] == 24'h0) else $error("read upper bits set");
  match_cause_a: assert property (ADDR_MATCH |-> $past(TOKEN_VALID)) else $error("match without token");
  ept_bits_a: assert property (ENDPOINT_TABLE_POINTER[0] == 1'b0 && ENDPOINT_TABLE_POINTER[15:12] == 4'h0)
    else $error("table pointer bits set");
  irq_level_a: assert property (IRQ_REQ == (IRQ_LEVEL != 2'h0)) else $error("level and request differ");
  push_slot_a: assert property (done_s ##1 DONE_FIFO_PUSH |-> DONE_FIFO_SLOT == slot_model)
    else $error("push slot wrong");
  push_source_a: assert property (DONE_FIFO_PUSH |-> $past(TRANSFER_DONE || SETUP_DONE)) else $error("push without done");
  push_entry_a: assert property (DONE_FIFO_PUSH |-> DONE_FIFO_ENTRY[2:0] == $past(ENDPOINT_TABLE_POINTER[2:0]) &&
    DONE_FIFO_ENTRY[3] == ($past(ENDPOINT_TABLE_POINTER[3]) ^ $past(DONE_EP_IN)))
    else $error("entry direction wrong");
endmodule
bind usb_device_addr_irq_regs usb_regs_checker usb_regs_checker_inst (.REF_CLK(REF_CLK), .RST(RST), .CYC_I(CYC_I),
  .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
  .TOKEN_VALID(TOKEN_VALID), .ADDR_MATCH(ADDR_MATCH), .TRANSFER_DONE(TRANSFER_DONE), .SETUP_DONE(SETUP_DONE),
  .DONE_EP_IN(DONE_EP_IN), .DONE_FIFO_PUSH(DONE_FIFO_PUSH), .DONE_FIFO_SLOT(DONE_FIFO_SLOT),
  .DONE_FIFO_ENTRY(DONE_FIFO_ENTRY), .ENDPOINT_TABLE_POINTER(ENDPOINT_TABLE_POINTER), .IRQ_REQ(IRQ_REQ),
  .IRQ_LEVEL(IRQ_LEVEL));

// [bench/usb_device_addr_irq_regs_tb.sv]
module usb_device_addr_irq_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, cyc, stb, we, ack, se0, idle, tok_v, match, td, sd, ep_in, pop, push, irq;
  logic [7:0]  adr, q, a, b, f, g, c;
  logic [31:0] wdat, rdat;
  logic [6:0]  tok_a;
  logic [4:0]  evt, slot;
  logic [3:0]  ep;
  logic [15:0] entry, eptp;
  logic [1:0]  lvl;
  logic [7:0]  v [5];
  int          error_cnt, samples_checked, cycles;
  localparam logic [5:0] IDX [5] = '{6'h03, 6'h06, 6'h07, 6'h08, 6'h09};
  localparam logic [7:0] WM [5] = '{8'h7F, 8'hFF, 8'hFF, 8'hF3, 8'h03};
  localparam logic [7:0] RM [5] = '{8'h7F, 8'hFE, 8'h0F, 8'hF3, 8'h03};
  localparam logic [5:0] ALL [14] = '{6'h00, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h09, 6'h0A, 6'h0B,
    6'h0C, 6'h0D, 6'h3F};
  usb_host_model usb_host_model_inst (.clk(clk), .se0(se0), .idle(idle), .tok_v(tok_v), .tok_a(tok_a), .evt(evt));
  usb_device_addr_irq_regs #(.SUSPEND_CYCLES(40)) usb_device_addr_irq_regs_inst (.REF_CLK(clk), .RST(rst),
    .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(4'h1), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack),
    .LINE_SE0(se0), .LINE_IDLE(idle), .TOKEN_VALID(tok_v), .TOKEN_ADDR(tok_a), .ADDR_MATCH(match),
    .FRAME_START_SEEN(evt[4]), .ISO_CHECK_ERROR(evt[3]), .IN_UNDERRUN(evt[2]), .OUT_OVERRUN(evt[1]),
    .STALL_SENT(evt[0]), .TRANSFER_DONE(td), .SETUP_DONE(sd), .DONE_EP_NUM(ep), .DONE_EP_IN(ep_in),
    .DONE_FIFO_POP(pop), .DONE_FIFO_PUSH(push), .DONE_FIFO_SLOT(slot), .DONE_FIFO_ENTRY(entry),
    .ENDPOINT_TABLE_POINTER(eptp), .IRQ_REQ(irq), .IRQ_LEVEL(lvl));
  function automatic logic exp_irq(logic [7:0] ca, logic [7:0] cb, logic [7:0] fa, logic [7:0] fb);
    exp_irq = (ca[1:0] != 2'h0) && ((ca[7] & fa[7]) | (ca[6] & |fa[6:4]) | (ca[5] & |fa[3:1]) | (ca[4] & fa[0])
      | (cb[1] & fb[1]) | (cb[0] & fb[0]));
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wb(input logic w, input logic [5:0] i, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    wdat <= {24'h0, d};
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic done_pulse(input logic s, input int k);
    @(posedge clk);
    td <= !s;
    sd <= s;
    ep <= 4'($urandom);
    ep_in <= 1'($urandom);
    @(posedge clk);
    td <= 1'b0;
    sd <= 1'b0;
    #1;
    chk("push", 1, push);
    chk("slot", k, slot);
    chk("entry", ({v[2], v[1]} & 16'h0FFE) + {8'h0, ep, 4'h0} + {12'h0, ep_in, 3'h0}, entry);
  endtask
  task automatic complete_run;
    $display("checked %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      error_cnt++;
      complete_run;
    end
  end
  initial
  begin
    {rst, cyc, stb, we, td, sd, ep_in, pop, adr, wdat, ep} = {1'b1, 7'h0, 8'h0, 32'h0, 4'h0};
    void'($urandom(32'h5ad4fb3f));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    foreach (ALL[k])
    begin
      wb(0, ALL[k], 8'h00);
      chk("reset value", 0, q);
    end
    for (int k = 0; k < 5; k++)
    begin
      v[k] = 8'($urandom) & WM[k];
      wb(1, IDX[k], v[k]);
      wb(0, IDX[k], 8'h00);
      v[k] = v[k] & RM[k];
      chk("readback", v[k], q);
    end
    repeat (2) @(posedge clk);
    #1 chk("table pointer", {v[2], v[1]} & 16'h0FFE, eptp);
    usb_host_model_inst.token(v[0][6:0]);
    #1 chk("match", 1, match);
    usb_host_model_inst.token(v[0][6:0] ^ 7'h41);
    #1 chk("no match", 0, match);
    for (int i = 0; i < 12; i++)
    begin
      a = 8'($urandom) & 8'hF3;
      b = 8'($urandom) & 8'h03;
      f = 8'($urandom);
      g = 8'($urandom) & 8'h03;
      if (i == 0)
        {a, b, f, g} = {8'hF0, 8'h03, 8'hFF, 8'h03};
      wb(1, 6'h08, a);
      wb(1, 6'h09, b);
      wb(1, 6'h0A, 8'hFF);
      wb(1, 6'h0B, f);
      wb(1, 6'h0C, 8'h03);
      wb(1, 6'h0D, g);
      wb(1, 6'h0A, 8'h00);
      wb(0, 6'h0A, 8'h00);
      chk("flags clear view", f, q);
      c = 8'($urandom);
      wb(1, 6'h0A, c);
      f = f & ~c;
      wb(1, 6'h0B, 8'h00);
      wb(0, 6'h0B, 8'h00);
      chk("flags set view", f, q);
      @(posedge clk);
      #1 chk("irq", exp_irq(a, b, f, g), irq);
      chk("level", exp_irq(a, b, f, g) ? a[1:0] : 2'h0, lvl);
    end
    for (int k = 0; k < 5; k++)
    begin
      wb(1, 6'h0A, 8'hFF);
      usb_host_model_inst.event_pulse(5'(1 << k));
      wb(0, 6'h0A, 8'h00);
      chk("event flag", (k == 4) ? 8'h80 : 8'(1 << k), q);
    end
    for (int k = 0; k < 4; k++)
    begin
      wb(1, 6'h0A, 8'hFF);
      if (k < 2)
        usb_host_model_inst.line_se0(312 + k);
      else
        usb_host_model_inst.line_idle(37 + k);
      wb(0, 6'h0A, 8'h00);
      chk("line flag", (k == 1) ? 8'h10 : (k == 3) ? 8'h60 : 8'h00, q);
    end
    wb(1, 6'h00, 8'h20);
    wb(1, 6'h04, 8'h00);
    for (int k = 0; k < 3; k++)
      done_pulse(k == 2, k);
    wb(0, 6'h04, 8'h00);
    chk("write pointer", 3, q);
    @(posedge clk) pop <= 1'b1;
    @(posedge clk) pop <= 1'b0;
    wb(0, 6'h05, 8'h00);
    chk("read pointer", 1, q);
    wb(1, 6'h05, 8'h00);
    wb(0, 6'h04, 8'h00);
    chk("flushed write pointer", 0, q);
    wb(0, 6'h05, 8'h00);
    chk("flushed read pointer", 0, q);
    complete_run;
  end
endmodule
